// >>> rtl/ced_pkg.sv
// Constants, encodings and types shared by the comparator event logic.
package ced_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [9:0] CED_IDX_CSR = 10'h0a3;
    localparam logic [9:0] CED_IDX_SCFG = 10'h0a4;
    localparam logic [9:0] CED_IDX_GIE = 10'h0a5;
    localparam logic [9:0] CED_IDX_ISTAT = 10'h0a6;
    localparam logic [9:0] CED_IDX_IMASK = 10'h0a7;
    localparam int CED_ADDR_W = 12;
    // Control/status register field positions.
    localparam int CED_CSR_CHAN_LSB = 6;
    localparam int CED_CSR_CONNECT = 5;
    localparam int CED_CSR_FLAG = 4;
    localparam int CED_CSR_ENABLE = 3;
    localparam int CED_CSR_MODE_LSB = 0;
    // Sample configuration register field positions.
    localparam int CED_SCFG_SEL_LSB = 0;
    localparam int CED_SCFG_REF_LSB = 2;
    localparam int CED_SCFG_RAW = 4;
    // Global interrupt enable bit for the comparator request.
    localparam int CED_GIE_COMP_BIT = 6;
    // Interrupt status bits: accepted event and discarded debounce.
    localparam int CED_IRQ_EVENT = 0;
    localparam int CED_IRQ_DISCARD = 1;
    localparam int CED_IRQ_W = 2;
    // Reset values.
    localparam logic [7:0] CED_CSR_RESET = 8'h00;
    localparam logic [3:0] CED_SCFG_RESET = 4'h0;
    localparam logic [CED_IRQ_W-1:0] CED_IRQ_RESET = 2'h0;
    // Event mode encodings.
    localparam logic [2:0] CED_MODE_LOW = 3'h0;
    localparam logic [2:0] CED_MODE_RISE = 3'h1;
    localparam logic [2:0] CED_MODE_DB_TOGGLE = 3'h2;
    localparam logic [2:0] CED_MODE_DB_RISE = 3'h3;
    localparam logic [2:0] CED_MODE_FALL = 3'h4;
    localparam logic [2:0] CED_MODE_TOGGLE = 3'h5;
    localparam logic [2:0] CED_MODE_DB_FALL = 3'h6;
    localparam logic [2:0] CED_MODE_HIGH = 3'h7;
    // Sample clock select encodings.
    localparam logic [1:0] CED_SEL_SYSCLK = 2'h0;
    localparam logic [1:0] CED_SEL_T0 = 2'h1;
    localparam logic [1:0] CED_SEL_T1 = 2'h2;
    localparam logic [1:0] CED_SEL_T2 = 2'h3;
    // Stable samples needed under timer pacing, and Timer 1 overflows to wait.
    localparam int CED_STABLE_SAMPLES = 4;
    localparam logic [1:0] CED_DB_OVF_COUNT = 2'h2;
    // Debouncer state.
    typedef enum logic {CED_DB_IDLE, CED_DB_WAIT} ced_dbs_t;
endpackage

// >>> rtl/ced_evt_if.sv
// Interface carrying samples and events between the top and the debouncer.
`timescale 1ns/1ps
interface ced_evt_if;
    logic sampleStb; // High for each cycle with a new accepted sample; stays high under system-clock sampling.
    logic accLevel; // Accepted (filtered) comparator level.
    logic liveLevel; // Enable-gated comparator level for resampling.
    logic enable; // Comparator enable.
    logic [2:0] mode; // Event mode select.
    logic t1Ovf; // Timer 1 overflow pulse.
    logic eventPulse; // High for each cycle with a valid event; the level modes under system-clock sampling keep it high while the level holds.
    logic discardPulse; // One-cycle pulse: a debounced edge was rejected.
    modport ctl (output sampleStb, accLevel, liveLevel, enable, mode, t1Ovf, input eventPulse, discardPulse);
    modport filt (input sampleStb, accLevel, liveLevel, enable, mode, t1Ovf, output eventPulse, discardPulse);
endinterface

// >>> rtl/ced_debouncer.sv
// Edge, level and toggle detection with Timer 1 debouncing.
`timescale 1ns/1ps
module ced_debouncer (
    input wire logic mclk,
    input wire logic reset,
    ced_evt_if.filt ev
);
    import ced_pkg::*;

    logic prevLevel_reg; // Previously stored accepted sample.
    logic prevLevel_next;
    ced_dbs_t state_reg; // Debounce state.
    ced_dbs_t state_next;
    logic expect_reg; // Level expected after the transition.
    logic expect_next;
    logic [1:0] ovfCnt_reg; // Timer 1 overflows seen while waiting.
    logic [1:0] ovfCnt_next;
    logic event_reg; // Registered event pulse.
    logic event_next;
    logic discard_reg; // Registered discard pulse.
    logic discard_next;

    // Transition decode against the stored sample, and level hits on the new sample.
    wire rise = ev.sampleStb && ev.accLevel && !prevLevel_reg;
    wire fall = ev.sampleStb && !ev.accLevel && prevLevel_reg;
    wire lowHit = ev.sampleStb && !ev.accLevel;
    wire highHit = ev.sampleStb && ev.accLevel;
    wire isDebounce = (ev.mode == CED_MODE_DB_TOGGLE) || (ev.mode == CED_MODE_DB_RISE) ||
                      (ev.mode == CED_MODE_DB_FALL);
    // Debounced modes arm on the transition they watch for.
    wire dbArm = ((ev.mode == CED_MODE_DB_TOGGLE) && (rise || fall)) ||
                 ((ev.mode == CED_MODE_DB_RISE) && rise) ||
                 ((ev.mode == CED_MODE_DB_FALL) && fall);
    wire lastOvf = ev.t1Ovf && (ovfCnt_reg == CED_DB_OVF_COUNT - 2'h1);

    // Immediate event condition for the non-debounced modes.
    logic directHit;
    always_comb begin
        case (ev.mode)
            CED_MODE_LOW: directHit = lowHit;
            CED_MODE_HIGH: directHit = highHit;
            CED_MODE_RISE: directHit = rise;
            CED_MODE_FALL: directHit = fall;
            CED_MODE_TOGGLE: directHit = rise || fall;
            default: directHit = 1'b0;
        endcase
    end

    // Next-state logic for the debounce wait and the event outputs.
    always_comb begin
        prevLevel_next = ev.sampleStb ? ev.accLevel : prevLevel_reg;
        state_next = state_reg;
        expect_next = expect_reg;
        ovfCnt_next = ovfCnt_reg;
        event_next = 1'b0;
        discard_next = 1'b0;
        case (state_reg)
            CED_DB_IDLE: begin
                if (ev.enable && isDebounce && dbArm) begin
                    state_next = CED_DB_WAIT;
                    expect_next = ev.accLevel;
                    ovfCnt_next = 2'h0;
                end else begin
                    event_next = ev.enable && !isDebounce && directHit;
                end
            end
            CED_DB_WAIT: begin
                if (!ev.enable || !isDebounce) begin
                    // Disable or a change to a non-debounced mode abandons the pending check.
                    state_next = CED_DB_IDLE;
                end else if (ev.t1Ovf) begin
                    // Overflows after the arming cycle only are counted.
                    ovfCnt_next = ovfCnt_reg + 2'h1;
                    if (lastOvf) begin
                        state_next = CED_DB_IDLE;
                        event_next = (ev.liveLevel == expect_reg);
                        discard_next = (ev.liveLevel != expect_reg);
                    end
                end
            end
            default: state_next = CED_DB_IDLE;
        endcase
    end

    // State registers.
    always_ff @(posedge mclk) begin
        if (reset) begin
            prevLevel_reg <= 1'b0;
            state_reg <= CED_DB_IDLE;
            expect_reg <= 1'b0;
            ovfCnt_reg <= 2'h0;
            event_reg <= 1'b0;
            discard_reg <= 1'b0;
        end else begin
            prevLevel_reg <= prevLevel_next;
            state_reg <= state_next;
            expect_reg <= expect_next;
            ovfCnt_reg <= ovfCnt_next;
            event_reg <= event_next;
            discard_reg <= discard_next;
        end
    end

    assign ev.eventPulse = event_reg;
    assign ev.discardPulse = discard_reg;
endmodule

// >>> rtl/ced_comparator_events.sv
// Top of the comparator event logic: APB registers, sampling and outputs.
`timescale 1ns/1ps
module ced_comparator_events (
    input wire logic mclk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ced_pkg::CED_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator and timers.
    input wire logic compRaw,
    input wire logic t0Ovf,
    input wire logic t1Ovf,
    input wire logic t2Ovf,
    input wire logic [3:0] analogPinUse,
    // Analog and interrupt outputs.
    output logic compOut,
    output logic [1:0] posChanSelect,
    output logic [1:0] referenceSelect,
    output logic [3:0] analogConnect,
    output logic [3:0] digInDisable,
    output logic compIrqReq,
    output logic irq
);
    import ced_pkg::*;

    // Register storage.
    logic [1:0] chanSel_reg; // Positive input channel select.
    logic [1:0] chanSel_next;
    logic connect_reg; // Input connect.
    logic connect_next;
    logic flag_reg; // Comparator event flag.
    logic flag_next;
    logic enable_reg; // Comparator enable.
    logic enable_next;
    logic [2:0] mode_reg; // Event mode select.
    logic [2:0] mode_next;
    logic [1:0] sampleSel_reg; // Sample clock select.
    logic [1:0] sampleSel_next;
    logic [1:0] refSel_reg; // Reference select.
    logic [1:0] refSel_next;
    logic gie_reg; // Global enable for the comparator request.
    logic gie_next;
    logic [CED_IRQ_W-1:0] istat_reg; // Sticky interrupt status.
    logic [CED_IRQ_W-1:0] istat_next;
    logic [CED_IRQ_W-1:0] imask_reg; // Interrupt mask.
    logic [CED_IRQ_W-1:0] imask_next;
    logic [31:0] rdata_reg; // Read data captured in the setup phase.
    logic [31:0] rdata_next;

    // Sampling storage.
    logic compOut_reg; // Enable-gated comparator level.
    logic [CED_STABLE_SAMPLES-2:0] hist_reg; // Recent timer-paced samples.
    logic [CED_STABLE_SAMPLES-2:0] hist_next;
    logic accLevel_reg; // Accepted level handed to the debouncer.
    logic accLevel_next;
    logic stb_reg; // Strobe aligned with the accepted level.

    // Returns the register index of a byte address, or all ones if unaligned.
    function automatic logic [9:0] regIndex(input logic [CED_ADDR_W-1:0] addr);
        if (addr[1:0] != 2'h0) begin
            regIndex = 10'h3ff;
        end else begin
            regIndex = addr[CED_ADDR_W-1:2];
        end
    endfunction

    // APB decode.
    wire [9:0] idx = regIndex(paddr);
    wire setupPh = psel && !penable;
    wire accessPh = psel && penable;
    wire hitCsr = (idx == CED_IDX_CSR);
    wire hitScfg = (idx == CED_IDX_SCFG);
    wire hitGie = (idx == CED_IDX_GIE);
    wire hitIstat = (idx == CED_IDX_ISTAT);
    wire hitImask = (idx == CED_IDX_IMASK);
    wire mapped = hitCsr || hitScfg || hitGie || hitIstat || hitImask;
    wire wrEn = accessPh && pwrite && mapped;
    wire wrCsr = wrEn && hitCsr;
    wire wrScfg = wrEn && hitScfg;
    wire wrGie = wrEn && hitGie;
    wire wrIstat = wrEn && hitIstat;
    wire wrImask = wrEn && hitImask;

    // Zero wait states; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = accessPh && !mapped;

    // Sample strobe selection.
    logic sampleStb;
    always_comb begin
        case (sampleSel_reg)
            CED_SEL_SYSCLK: sampleStb = 1'b1;
            CED_SEL_T0: sampleStb = t0Ovf;
            CED_SEL_T1: sampleStb = t1Ovf;
            CED_SEL_T2: sampleStb = t2Ovf;
            default: sampleStb = 1'b0;
        endcase
    end

    // Timer pacing needs the current and previous samples all equal.
    wire allHigh = compOut_reg && (&hist_reg);
    wire allLow = !compOut_reg && !(|hist_reg);

    // Accepted level and sample history.
    always_comb begin
        hist_next = hist_reg;
        accLevel_next = accLevel_reg;
        if (sampleStb) begin
            hist_next = {hist_reg[CED_STABLE_SAMPLES-3:0], compOut_reg};
            if (sampleSel_reg == CED_SEL_SYSCLK) begin
                accLevel_next = compOut_reg;
            end else if (allHigh) begin
                accLevel_next = 1'b1;
            end else if (allLow) begin
                accLevel_next = 1'b0;
            end
        end
    end

    // Debouncer hook-up.
    ced_evt_if evIf ();
    assign evIf.sampleStb = stb_reg;
    assign evIf.accLevel = accLevel_reg;
    assign evIf.liveLevel = compOut_reg;
    assign evIf.enable = enable_reg;
    assign evIf.mode = mode_reg;
    assign evIf.t1Ovf = t1Ovf;

    ced_debouncer debounce (
        .mclk(mclk),
        .reset(reset),
        .ev(evIf.filt)
    );

    // Control/status register updates.
    always_comb begin
        chanSel_next = chanSel_reg;
        connect_next = connect_reg;
        enable_next = enable_reg;
        mode_next = mode_reg;
        flag_next = flag_reg;
        if (wrCsr) begin
            chanSel_next = pwdata[CED_CSR_CHAN_LSB +: 2];
            connect_next = pwdata[CED_CSR_CONNECT];
            enable_next = pwdata[CED_CSR_ENABLE];
            mode_next = pwdata[CED_CSR_MODE_LSB +: 3];
            // Writing zero clears the flag; writing one leaves it.
            if (!pwdata[CED_CSR_FLAG]) begin
                flag_next = 1'b0;
            end
        end
        // A new event wins over a clear in the same cycle.
        if (evIf.eventPulse) begin
            flag_next = 1'b1;
        end
    end

    // Configuration, global enable, status and mask updates.
    always_comb begin
        sampleSel_next = wrScfg ? pwdata[CED_SCFG_SEL_LSB +: 2] : sampleSel_reg;
        refSel_next = wrScfg ? pwdata[CED_SCFG_REF_LSB +: 2] : refSel_reg;
        gie_next = wrGie ? pwdata[CED_GIE_COMP_BIT] : gie_reg;
        imask_next = wrImask ? pwdata[CED_IRQ_W-1:0] : imask_reg;
        istat_next = istat_reg;
        if (wrIstat) begin
            istat_next = istat_reg & ~pwdata[CED_IRQ_W-1:0];
        end
        // Hardware sets win over write-one-to-clear.
        istat_next[CED_IRQ_EVENT] = istat_next[CED_IRQ_EVENT] | evIf.eventPulse;
        istat_next[CED_IRQ_DISCARD] = istat_next[CED_IRQ_DISCARD] | evIf.discardPulse;
    end

    // Read multiplexer; the value is captured during the setup phase.
    always_comb begin
        rdata_next = rdata_reg;
        if (setupPh) begin
            rdata_next = 32'h0000_0000;
            if (hitCsr) begin
                rdata_next[7:0] = {chanSel_reg, connect_reg, flag_reg, enable_reg, mode_reg};
            end else if (hitScfg) begin
                rdata_next[CED_SCFG_SEL_LSB +: 2] = sampleSel_reg;
                rdata_next[CED_SCFG_REF_LSB +: 2] = refSel_reg;
                rdata_next[CED_SCFG_RAW] = compOut_reg;
            end else if (hitGie) begin
                rdata_next[CED_GIE_COMP_BIT] = gie_reg;
            end else if (hitIstat) begin
                rdata_next[CED_IRQ_W-1:0] = istat_reg;
            end else if (hitImask) begin
                rdata_next[CED_IRQ_W-1:0] = imask_reg;
            end
        end
    end

    // Register process for software-visible state.
    always_ff @(posedge mclk) begin
        if (reset) begin
            {chanSel_reg, connect_reg, flag_reg, enable_reg, mode_reg} <= CED_CSR_RESET;
            {refSel_reg, sampleSel_reg} <= CED_SCFG_RESET;
            gie_reg <= 1'b0;
            istat_reg <= CED_IRQ_RESET;
            imask_reg <= CED_IRQ_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            chanSel_reg <= chanSel_next;
            connect_reg <= connect_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
            mode_reg <= mode_next;
            sampleSel_reg <= sampleSel_next;
            refSel_reg <= refSel_next;
            gie_reg <= gie_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            rdata_reg <= rdata_next;
        end
    end

    // Register process for the sampling path.
    always_ff @(posedge mclk) begin
        if (reset) begin
            compOut_reg <= 1'b0;
            hist_reg <= '0;
            accLevel_reg <= 1'b0;
            stb_reg <= 1'b0;
        end else begin
            // A disabled comparator reads as low.
            compOut_reg <= compRaw && enable_reg;
            hist_reg <= hist_next;
            accLevel_reg <= accLevel_next;
            stb_reg <= sampleStb;
        end
    end

    // Only the selected pin joins the comparator, and only when connected.
    function automatic logic [3:0] pinDecode(input logic [1:0] sel);
        pinDecode = 4'h1 << sel;
    endfunction

    // Output assignments.
    assign prdata = rdata_reg;
    assign compOut = compOut_reg;
    assign posChanSelect = chanSel_reg;
    assign referenceSelect = refSel_reg;
    assign analogConnect = connect_reg ? pinDecode(chanSel_reg) : 4'h0;
    assign digInDisable = enable_reg ? analogPinUse : 4'h0;
    assign compIrqReq = flag_reg && gie_reg;
    assign irq = |(istat_reg & imask_reg);
endmodule

// >>> dv/ced_partner.sv
// Far-side model: comparator output and three free-running timer overflows.
`timescale 1ns/1ps
module ced_partner #(
    parameter int T0_PERIOD = 5,
    parameter int T1_PERIOD = 8,
    parameter int T2_PERIOD = 11
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic level,
    output logic compRaw = 1'b0,
    output logic t0Ovf = 1'b0,
    output logic t1Ovf = 1'b0,
    output logic t2Ovf = 1'b0
);
    int cnt = 0; // Shared free-running timer count.
    // Overflows are one-cycle pulses; the comparator settles one cycle after the analog level moves.
    always @(posedge mclk) begin
        cnt <= reset ? 0 : cnt + 1;
        compRaw <= level;
        t0Ovf <= (cnt % T0_PERIOD) == T0_PERIOD - 1;
        t1Ovf <= (cnt % T1_PERIOD) == T1_PERIOD - 1;
        t2Ovf <= (cnt % T2_PERIOD) == T2_PERIOD - 1;
    end
endmodule

// >>> dv/ced_comparator_events_chk.sv
// Port checker for the comparator event logic, bound onto its top module.
`timescale 1ns/1ps
module ced_comparator_events_chk (
    input wire logic mclk, reset, psel, penable, pwrite, pready, pslverr,
    input wire logic [ced_pkg::CED_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic compRaw, compOut, compIrqReq, irq,
    input wire logic [3:0] analogPinUse, analogConnect, digInDisable
);
    import ced_pkg::*;
    localparam logic [11:0] A_CSR = {CED_IDX_CSR, 2'h0};
    localparam logic [11:0] A_SCFG = {CED_IDX_SCFG, 2'h0};
    localparam logic [11:0] A_GIE = {CED_IDX_GIE, 2'h0};
    localparam logic [11:0] A_MSK = {CED_IDX_IMASK, 2'h0};
    wire logic wrDone = psel && penable && pwrite && pready; // A completed write.
    wire logic csrWr = wrDone && paddr == A_CSR; // A write to the control register.
    wire logic mapped = paddr[1:0] == 2'h0 && paddr[11:2] >= CED_IDX_CSR && paddr[11:2] <= CED_IDX_IMASK;
    logic enSh, conSh, gieSh; // Mirrors of software-written bits.
    logic [1:0] chanSh, selSh, mskSh;
    logic [2:0] modeSh;
    // Mirror completed writes to CSR, SCFG, GIE and IMASK so outputs can be tied to their cause.
    always_ff @(posedge mclk) begin
        if (reset) begin
            {enSh, conSh, gieSh, chanSh, selSh, mskSh, modeSh} <= '0;
        end else begin
            if (csrWr) {chanSh, conSh, enSh, modeSh} <= {pwdata[7:5], pwdata[3:0]};
            if (wrDone && paddr == A_GIE) gieSh <= pwdata[6];
            if (wrDone && paddr == A_MSK) mskSh <= pwdata[1:0];
            if (wrDone && paddr == A_SCFG) selSh <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_slverr_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("No error on unmapped access.");
    a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("Upper read bits not zero.");
    a_out_gated: assert property (!enSh && !$past(enSh) |-> !compOut)
        else $error("Output not low while disabled.");
    a_out_tracks: assert property (enSh && $past(enSh) |-> compOut == $past(compRaw))
        else $error("Output does not follow comparator.");
    a_dig_off: assert property (digInDisable == (enSh ? analogPinUse : 4'h0))
        else $error("Digital input disable wrong.");
    a_pin_connect: assert property (analogConnect == (conSh ? 4'(1 << chanSh) : 4'h0))
        else $error("Pin connection wrong.");
    a_req_gate: assert property (compIrqReq |-> gieSh)
        else $error("Request without global enable.");
    a_flag_hold: assert property ($past(compIrqReq) && gieSh && $past(gieSh) && !$past(csrWr) |-> compIrqReq)
        else $error("Flag cleared without software.");
    a_irq_masked: assert property (irq |-> mskSh != 2'h0)
        else $error("Interrupt with all sources masked.");
    a_rise_latency: assert property ($rose(compOut) && enSh && gieSh && modeSh == CED_MODE_RISE
        && selSh == CED_SEL_SYSCLK |-> ##[1:4] compIrqReq)
        else $error("Rising edge not flagged in time.");
    c_req: cover property ($rose(compIrqReq));
    c_irq: cover property ($rose(irq));
    c_err: cover property (psel && penable && pslverr);
endmodule
bind ced_comparator_events ced_comparator_events_chk ced_comparator_events_chk_inst (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .compRaw(compRaw), .compOut(compOut),
    .compIrqReq(compIrqReq), .irq(irq), .analogPinUse(analogPinUse), .analogConnect(analogConnect),
    .digInDisable(digInDisable)
);

// >>> dv/testbench.sv
// Self-checking bench for the comparator event logic.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %0t: got %h want %h", $time, g, e); end end
module testbench;
    import ced_pkg::*;
    localparam logic [11:0] A_CSR = {CED_IDX_CSR, 2'h0};
    localparam logic [11:0] A_SCFG = {CED_IDX_SCFG, 2'h0};
    localparam logic [11:0] A_GIE = {CED_IDX_GIE, 2'h0};
    localparam logic [11:0] A_IST = {CED_IDX_ISTAT, 2'h0};
    localparam logic [11:0] A_MSK = {CED_IDX_IMASK, 2'h0};
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, level = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic pready, pslverr, compRaw, t0Ovf, t1Ovf, t2Ovf, compOut, compIrqReq, irq;
    logic [3:0] analogPinUse = 4'ha, analogConnect, digInDisable;
    logic [1:0] posChanSelect, referenceSelect;
    int n_fail = 0, n_checks = 0;
    ced_comparator_events ced_comparator_events_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compRaw(compRaw), .t0Ovf(t0Ovf), .t1Ovf(t1Ovf), .t2Ovf(t2Ovf), .analogPinUse(analogPinUse),
        .compOut(compOut), .posChanSelect(posChanSelect), .referenceSelect(referenceSelect),
        .analogConnect(analogConnect), .digInDisable(digInDisable), .compIrqReq(compIrqReq), .irq(irq));
    ced_partner ced_partner_inst (.mclk(mclk), .reset(reset), .level(level), .compRaw(compRaw),
        .t0Ovf(t0Ovf), .t1Ovf(t1Ovf), .t2Ovf(t2Ovf));
    // Clock at 40 MHz.
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("Checks %0d, mismatches %0d.", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // One APB transfer; waits a bounded time for pready, then one idle edge so outputs settle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_fail++;
            final_report();
        end
        rdat = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // Bounded wait for the next Timer 1 overflow.
    task automatic w1;
        int i;
        i = 0;
        while (t1Ovf !== 1'b1 && i < 40) begin
            i++;
            @(posedge mclk);
        end
        if (i >= 40) begin
            n_fail++;
            final_report();
        end
    endtask
    // Enable mode m at level a, clear the flag, move the level to b and read back the flag.
    task automatic evt(input logic [2:0] m, input logic a, input logic b, input logic ex);
        level <= a;
        wr(A_CSR, {29'h1, m});
        cyc(6);
        wr(A_CSR, {29'h1, m});
        level <= b;
        cyc(8);
        rdc(A_CSR, {27'h0, ex, 1'b1, m});
    endtask
    // Debounced edge starting right after an overflow; optional glitch back to a.
    task automatic db(input logic [2:0] m, input logic a, input logic b, input int g, input logic ex);
        level <= a;
        wr(A_CSR, {29'h1, m});
        cyc(30);
        wr(A_CSR, {29'h1, m});
        wr(A_IST, 32'h3);
        w1();
        level <= b;
        if (g > 0) begin
            cyc(g);
            level <= a;
        end
        cyc(1);
        w1();
        cyc(1);
        w1();
        `CHK(compIrqReq, 1'b0)
        cyc(4);
        `CHK(compIrqReq, ex)
        rdc(A_IST, {30'h0, !ex, ex});
    endtask
    // Timeout guard.
    initial begin
        cyc(20000);
        n_fail++;
        final_report();
    end
    // Main sequence.
    initial begin
        cyc(10);
        reset <= 1'b0;
        rdc(A_CSR, 32'h0);
        rdc(A_SCFG, 32'h0);
        rdc(A_GIE, 32'h0);
        rdc(A_IST, 32'h0);
        rdc(A_MSK, 32'h0);
        rdc(12'h2a0, 32'h0);
        `CHK(err, 1'b1)
        wr(12'h28d, 32'hff);
        `CHK(err, 1'b1)
        rdc(A_CSR, 32'h0);
        $display("Register test done.");
        for (int c = 0; c < 4; c++) begin
            wr(A_CSR, 32'(c << 6));
            wr(A_CSR, 32'(c << 6) | 32'h28);
            `CHK(analogConnect, 4'(1 << c))
            `CHK(posChanSelect, 2'(c))
            `CHK(digInDisable, analogPinUse)
        end
        wr(A_CSR, 32'h0);
        wr(A_SCFG, 32'h8);
        `CHK(referenceSelect, 2'h2)
        `CHK(analogConnect, 4'h0)
        `CHK(digInDisable, 4'h0)
        wr(A_SCFG, 32'h0);
        $display("Connect test done.");
        evt(CED_MODE_LOW, 1'b1, 1'b1, 1'b0);
        evt(CED_MODE_LOW, 1'b1, 1'b0, 1'b1);
        evt(CED_MODE_HIGH, 1'b0, 1'b0, 1'b0);
        evt(CED_MODE_HIGH, 1'b0, 1'b1, 1'b1);
        evt(CED_MODE_RISE, 1'b1, 1'b0, 1'b0);
        evt(CED_MODE_FALL, 1'b0, 1'b1, 1'b0);
        evt(CED_MODE_TOGGLE, 1'b1, 1'b0, 1'b1);
        evt(CED_MODE_TOGGLE, 1'b0, 1'b1, 1'b1);
        evt(CED_MODE_FALL, 1'b1, 1'b0, 1'b1);
        evt(CED_MODE_RISE, 1'b0, 1'b1, 1'b1);
        wr(A_IST, 32'h3);
        rdc(A_IST, 32'h0);
        evt(CED_MODE_FALL, 1'b1, 1'b0, 1'b1);
        rdc(A_IST, 32'h1);
        `CHK(irq, 1'b0)
        wr(A_MSK, 32'h1);
        `CHK(irq, 1'b1)
        `CHK(compIrqReq, 1'b0)
        wr(A_GIE, 32'h40);
        `CHK(compIrqReq, 1'b1)
        cyc(20);
        `CHK(compIrqReq, 1'b1)
        wr(A_MSK, 32'h2);
        `CHK(irq, 1'b0)
        evt(CED_MODE_RISE, 1'b0, 1'b1, 1'b1);
        $display("Event mode test done.");
        wr(A_CSR, 32'h4);
        level <= 1'b0;
        cyc(3);
        level <= 1'b1;
        cyc(3);
        `CHK(compOut, 1'b0)
        rdc(A_CSR, 32'h4);
        $display("Disable test done.");
        db(CED_MODE_DB_RISE, 1'b0, 1'b1, 0, 1'b1);
        db(CED_MODE_DB_FALL, 1'b1, 1'b0, 0, 1'b1);
        db(CED_MODE_DB_TOGGLE, 1'b0, 1'b1, 0, 1'b1);
        db(CED_MODE_DB_FALL, 1'b1, 1'b0, 2, 1'b0);
        $display("Debounce test done.");
        for (int s = 1; s < 4; s++) begin
            level <= 1'b0;
            wr(A_SCFG, 32'(s));
            wr(A_CSR, 32'h9);
            cyc(6 * (3 * s + 2));
            wr(A_CSR, 32'h9);
            level <= 1'b1;
            cyc(2 * (3 * s + 2));
            level <= 1'b0;
            cyc(6 * (3 * s + 2));
            `CHK(compIrqReq, 1'b0)
            level <= 1'b1;
            cyc(6 * (3 * s + 2));
            `CHK(compIrqReq, 1'b1)
        end
        // Timer 1 paces sampling: the flag follows two overflows after the capturing one.
        wr(A_SCFG, 32'h2);
        level <= 1'b0;
        wr(A_CSR, 32'hb);
        cyc(60);
        wr(A_CSR, 32'hb);
        w1();
        level <= 1'b1;
        repeat (6) begin
            cyc(1);
            w1();
        end
        `CHK(compIrqReq, 1'b0)
        cyc(4);
        `CHK(compIrqReq, 1'b1)
        $display("Timer sampling test done.");
        final_report();
    end
endmodule
